/* hdl/reset_mode_trap_entry.sv */
// Purpose : Trap entry for soft reset traps taken in hyper mode and for any other trap taken in recovery mode
// Assumes : Pipeline holds its request fields while trap_req is high and trap_ready low
// Notes   : Zero wait-state AHB-Lite slave; entry takes one cycle after the request
`timescale 1ns/1ps
module reset_mode_trap_entry
    import trap_entry_pkg::*;
(
    input  wire logic                            hclk,
    input  wire logic                            hresetn,
    input  wire logic                            hsel,
    input  wire logic [31:0]                     haddr,
    input  wire logic [1:0]                      htrans,
    input  wire logic                            hwrite,
    input  wire logic [2:0]                      hsize,
    input  wire logic [31:0]                     hwdata,
    input  wire logic                            hready,
    output logic      [31:0]                     hrdata,
    output logic                                 hreadyout,
    output logic                                 hresp,
    input  wire logic                            trap_req,
    input  wire logic                            soft_reset_instr,
    input  wire logic [trap_entry_pkg::TT_W-1:0] trap_kind_code,
    input  wire logic [63:0]                     cur_pc,
    input  wire logic [63:0]                     cur_next_pc,
    input  wire logic [7:0]                      cur_ccr,
    input  wire logic [7:0]                      cur_asi,
    input  wire logic [trap_entry_pkg::CWP_W-1:0] free_window_count,
    output logic                                 trap_ready,
    output logic                                 trap_done,
    output logic      [63:0]                     new_pc,
    output logic      [63:0]                     new_next_pc,
    output logic                                 error_mode
);
    import trap_entry_pkg::*;

    localparam int REC_W = TT_W + HS_W + GL_W + 16 + PS_W + CWP_W + 128;

    seq_state_t        state_r;
    logic [TD_W-1:0]   trap_depth_r;
    logic [GL_W-1:0]   reg_bank_depth_r;
    logic [CWP_W-1:0]  cwp_r;
    logic [PS_W-1:0]   pstate_r;
    logic [HS_W-1:0]   hpstate_r;
    logic [63:0]       reset_vector_base_r;
    logic [TD_W-1:0]   stk_sel_r;
    logic              cap_sir_r;
    logic [TT_W-1:0]   cap_tt_r;
    logic [63:0]       cap_pc_r;
    logic [63:0]       cap_npc_r;
    logic [7:0]        cap_ccr_r;
    logic [7:0]        cap_asi_r;
    logic [CWP_W-1:0]  cap_free_r;
    logic              take;
    logic              entering;
    logic              at_limit;
    logic [TD_W-1:0]   td_nxt;
    logic [GL_W-1:0]   gl_nxt;
    logic [CWP_W-1:0]  cwp_nxt;
    logic [PS_W-1:0]   ps_nxt;
    logic [HS_W-1:0]   hs_nxt;
    logic [TT_W-1:0]   rec_tt;
    logic [63:0]       save_pc;
    logic [63:0]       save_npc;
    logic              stk_we;
    logic [REC_W-1:0]  stk_wdata;
    logic [REC_W-1:0]  stk_rdata;
    logic [TT_W-1:0]   rd_tt;
    logic [HS_W-1:0]   rd_hs;
    logic [GL_W-1:0]   rd_gl;
    logic [15:0]       rd_ccr_asi;
    logic [PS_W-1:0]   rd_ps;
    logic [CWP_W-1:0]  rd_cwp;
    logic [63:0]       rd_pc;
    logic [63:0]       rd_npc;
    logic              ahb_wr_r;
    logic [7:0]        ahb_addr_r;
    logic              bus_wr;

    // ------------------------------------------------------------
    // Request acceptance and sequencing
    // ------------------------------------------------------------
    assign trap_ready = (state_r == ST_IDLE);
    // A soft reset outside hyper mode or a trap outside recovery mode is not ours
    assign take = trap_ready && trap_req &&
                  (soft_reset_instr ? hpstate_r[HS_HPRIV] : hpstate_r[HS_RED]);
    assign entering = (state_r == ST_ENTER);
    assign at_limit = (trap_depth_r == TRAP_DEPTH_LIMIT);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_r <= ST_IDLE;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                begin
                    if (take)
                    begin
                        state_r <= ST_ENTER;
                    end
                end
                ST_ENTER:
                begin
                    state_r <= at_limit ? ST_HALT : ST_IDLE;
                end
                ST_HALT:
                begin
                    state_r <= ST_HALT;
                end
                default:
                begin
                    state_r <= ST_HALT;
                end
            endcase
        end
    end

    // Request fields are frozen so the entry cycle sees one consistent snapshot
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cap_sir_r  <= 1'b0;
            cap_tt_r   <= '0;
            cap_pc_r   <= '0;
            cap_npc_r  <= '0;
            cap_ccr_r  <= '0;
            cap_asi_r  <= '0;
            cap_free_r <= '0;
        end
        else if (take)
        begin
            cap_sir_r  <= soft_reset_instr;
            cap_tt_r   <= soft_reset_instr ? TT_SOFT_RESET : trap_kind_code;
            cap_pc_r   <= cur_pc;
            cap_npc_r  <= cur_next_pc;
            cap_ccr_r  <= cur_ccr;
            cap_asi_r  <= cur_asi;
            cap_free_r <= free_window_count;
        end
    end

    // ------------------------------------------------------------
    // Next architectural state for the entry cycle
    // ------------------------------------------------------------
    assign rec_tt = cap_tt_r;
    assign td_nxt = trap_depth_r + TD_ONE;
    assign gl_nxt = (reg_bank_depth_r == REG_BANK_DEPTH_LIMIT) ?
                    reg_bank_depth_r : reg_bank_depth_r + GL_ONE;

    always_comb
    begin
        cwp_nxt = cwp_r;
        if (rec_tt == TT_CLEAN_WIN)
        begin
            cwp_nxt = cwp_r + CWP_ONE;
        end
        else if (rec_tt >= TT_SPILL_LO && rec_tt <= TT_SPILL_HI)
        begin
            cwp_nxt = cwp_r + cap_free_r + CWP_SPILL_BIAS;
        end
        else if (rec_tt >= TT_FILL_LO && rec_tt <= TT_FILL_HI)
        begin
            cwp_nxt = cwp_r - CWP_ONE;
        end
    end

    always_comb
    begin
        ps_nxt = pstate_r;
        ps_nxt[PS_MM_HI:PS_MM_LO] = MM_TSO;
        ps_nxt[PS_PEF]  = 1'b1;
        ps_nxt[PS_AM]   = 1'b0;
        ps_nxt[PS_PRIV] = 1'b0;
        ps_nxt[PS_IE]   = 1'b0;
        ps_nxt[PS_CLE]  = 1'b0;
        ps_nxt[PS_TCT]  = 1'b0;
        hs_nxt = hpstate_r;
        hs_nxt[HS_RED]   = 1'b1;
        hs_nxt[HS_HPRIV] = 1'b1;
        hs_nxt[HS_IBE]   = 1'b0;
        hs_nxt[HS_TLZ]   = 1'b0;
    end

    // ------------------------------------------------------------
    // Save stack, written at the new depth from pre-entry values
    // ------------------------------------------------------------
    assign save_pc  = pstate_r[PS_AM] ? {PC_HI_ZERO, cap_pc_r[31:0]} : cap_pc_r;
    assign save_npc = pstate_r[PS_AM] ? {PC_HI_ZERO, cap_npc_r[31:0]} : cap_npc_r;
    assign stk_we   = entering && !at_limit;
    assign stk_wdata = {rec_tt, hpstate_r, reg_bank_depth_r, cap_ccr_r, cap_asi_r,
                        pstate_r, cwp_r, save_pc, save_npc};
    assign {rd_tt, rd_hs, rd_gl, rd_ccr_asi, rd_ps, rd_cwp, rd_pc, rd_npc} = stk_rdata;

    trap_stack #(
        .WIDTH (REC_W),
        .DEPTH (STK_DEPTH),
        .AW    (TD_W)
    ) u_stack (
        .hclk  (hclk),
        .we    (stk_we),
        .waddr (td_nxt),
        .wdata (stk_wdata),
        .raddr (stk_sel_r),
        .rdata (stk_rdata)
    );

    // ------------------------------------------------------------
    // Architectural state; entry wins over a bus write in the same cycle
    // ------------------------------------------------------------
    assign bus_wr = ahb_wr_r && !stk_we;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            trap_depth_r     <= '0;
            reg_bank_depth_r <= '0;
            cwp_r            <= '0;
            pstate_r         <= PS_RESET;
            hpstate_r        <= HS_RESET;
        end
        else if (stk_we)
        begin
            trap_depth_r     <= td_nxt;
            reg_bank_depth_r <= gl_nxt;
            cwp_r            <= cwp_nxt;
            pstate_r         <= ps_nxt;
            hpstate_r        <= hs_nxt;
        end
        else if (bus_wr && ahb_addr_r == OFS_PSTATE)
        begin
            pstate_r <= hwdata[PS_W-1:0];
        end
        else if (bus_wr && ahb_addr_r == OFS_HPSTATE)
        begin
            hpstate_r <= hwdata[HS_W-1:0];
        end
        else if (bus_wr && ahb_addr_r == OFS_DEPTHS)
        begin
            trap_depth_r     <= hwdata[DP_TD +: TD_W];
            reg_bank_depth_r <= hwdata[DP_GL +: GL_W];
            cwp_r            <= hwdata[DP_CWP +: CWP_W];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            trap_done   <= 1'b0;
            new_pc      <= '0;
            new_next_pc <= '0;
        end
        else
        begin
            trap_done <= stk_we;
            if (stk_we)
            begin
                new_pc      <= {reset_vector_base_r[63:8],
                                cap_sir_r ? VEC_SIR_PC : VEC_RED_PC};
                new_next_pc <= {reset_vector_base_r[63:8],
                                cap_sir_r ? VEC_SIR_NPC : VEC_RED_NPC};
            end
        end
    end

    assign error_mode = (state_r == ST_HALT);

    // ------------------------------------------------------------
    // AHB-Lite slave, zero wait states, always OKAY
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ahb_wr_r   <= 1'b0;
            ahb_addr_r <= '0;
            hrdata     <= '0;
        end
        else if (hready)
        begin
            ahb_wr_r   <= hsel && htrans[1] && hwrite;
            ahb_addr_r <= haddr[7:0];
            hrdata     <= '0;
            if (hsel && htrans[1] && !hwrite && haddr[31:8] == '0)
            begin
                unique case (haddr[7:0])
                    OFS_PSTATE:    hrdata <= {{(32-PS_W){1'b0}}, pstate_r};
                    OFS_HPSTATE:   hrdata <= {{(32-HS_W){1'b0}}, hpstate_r};
                    OFS_DEPTHS:    hrdata <= {{(32-DP_CWP-CWP_W){1'b0}}, cwp_r, 1'b0,
                                              reg_bank_depth_r, 1'b0, trap_depth_r};
                    OFS_RVEC_LO:   hrdata <= reset_vector_base_r[31:0];
                    OFS_RVEC_HI:   hrdata <= reset_vector_base_r[63:32];
                    OFS_STATUS:    hrdata <= {30'h0000_0000, state_r};
                    OFS_STK_SEL:   hrdata <= {{(32-TD_W){1'b0}}, stk_sel_r};
                    OFS_STK_TT:    hrdata <= {{(32-TT_W){1'b0}}, rd_tt};
                    OFS_STK_PC_LO: hrdata <= rd_pc[31:0];
                    OFS_STK_PC_HI: hrdata <= rd_pc[63:32];
                    default:       hrdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            reset_vector_base_r <= {RVEC_HI_RESET, RVEC_LO_RESET};
            stk_sel_r           <= '0;
        end
        else if (ahb_wr_r)
        begin
            if (ahb_addr_r == OFS_RVEC_LO)
            begin
                reset_vector_base_r[31:0] <= hwdata;
            end
            if (ahb_addr_r == OFS_RVEC_HI)
            begin
                reset_vector_base_r[63:32] <= hwdata;
            end
            if (ahb_addr_r == OFS_STK_SEL)
            begin
                stk_sel_r <= hwdata[TD_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_take;
        trap_ready && trap_req;
    endsequence
    sequence s_enter;
        state_r == ST_ENTER;
    endsequence

    a_sir_gated: assert property ((s_take and (soft_reset_instr && !hpstate_r[HS_HPRIV]))
        |=> state_r == ST_IDLE) else $error("soft reset taken outside hyper mode");
    a_entry_seq: assert property (take |=> s_enter ##1 (trap_done ^ error_mode))
        else $error("trap entry did not finish in one cycle");
    a_halt_limit: assert property ((s_enter and at_limit) |=> error_mode && !trap_done
        && trap_depth_r == $past(trap_depth_r)) else $error("limit did not halt");
    a_depth_step: assert property (trap_done |-> trap_depth_r == $past(trap_depth_r) + TD_ONE
        && hpstate_r[HS_RED] && hpstate_r[HS_HPRIV] && !hpstate_r[HS_IBE]
        && !hpstate_r[HS_TLZ]) else $error("depth or hyper flags wrong");
    a_sir_code: assert property (stk_we && cap_sir_r |-> rec_tt == TT_SOFT_RESET)
        else $error("soft reset code not recorded");
    a_own_code: assert property ((s_take and !soft_reset_instr) ##1 stk_we
        |-> rec_tt == $past(trap_kind_code)) else $error("trap code not kept");
    a_pc_mask: assert property (stk_we && pstate_r[PS_AM]
        |-> stk_wdata[127:96] == PC_HI_ZERO && stk_wdata[63:32] == PC_HI_ZERO)
        else $error("saved PC high half not masked");
    a_bank_sat: assert property (trap_done |-> reg_bank_depth_r <= REG_BANK_DEPTH_LIMIT
        && reg_bank_depth_r >= $past(reg_bank_depth_r)) else $error("bank depth");
    a_pstate_set: assert property (trap_done |-> pstate_r[PS_MM_HI:PS_MM_LO] == MM_TSO
        && pstate_r[PS_PEF] && !pstate_r[PS_AM] && !pstate_r[PS_IE]
        && !pstate_r[PS_CLE] && !pstate_r[PS_PRIV]) else $error("entry state bits");
    a_tle_kept: assert property (trap_done |-> pstate_r[PS_TLE] == $past(pstate_r[PS_TLE])
        && !pstate_r[PS_TCT]) else $error("byte order or transfer trap bit");
    a_sir_vector: assert property (trap_done && cap_sir_r |-> new_pc[7:0] == VEC_SIR_PC
        && new_next_pc[7:0] == VEC_SIR_NPC && new_pc[63:8] == reset_vector_base_r[63:8])
        else $error("soft reset vector wrong");
    a_red_vector: assert property (trap_done && !cap_sir_r |-> new_pc[7:0] == VEC_RED_PC
        && new_next_pc[7:0] == VEC_RED_NPC) else $error("recovery vector wrong");
    a_win_clean: assert property (trap_done && cap_tt_r == TT_CLEAN_WIN
        |-> cwp_r == $past(cwp_r) + CWP_ONE) else $error("clean window pointer");
    a_win_fill: assert property (trap_done && cap_tt_r >= TT_FILL_LO
        && cap_tt_r <= TT_FILL_HI |-> cwp_r == $past(cwp_r) - CWP_ONE)
        else $error("fill window pointer");
    a_win_spill: assert property (trap_done && cap_tt_r >= TT_SPILL_LO
        && cap_tt_r <= TT_SPILL_HI |-> cwp_r == CWP_W'($past(cwp_r) + cap_free_r
        + CWP_SPILL_BIAS)) else $error("spill window pointer");
    a_win_other: assert property (trap_done && cap_tt_r != TT_CLEAN_WIN
        && cap_tt_r < TT_SPILL_LO |-> cwp_r == $past(cwp_r))
        else $error("window pointer moved");
endmodule

/* hdl/trap_entry_pkg.sv */
// Purpose : Constants, field layouts and states for the recovery-mode trap sequencer
// Assumes : One core clock; the register map is reached over AHB-Lite
// Notes   : Register offsets are byte addresses of aligned 32-bit words
package trap_entry_pkg;

    // ------------------------------------------------------------
    // Widths and limits
    // ------------------------------------------------------------
    localparam int TD_W  = 3;
    localparam int GL_W  = 3;
    localparam int CWP_W = 3;
    localparam int TT_W  = 9;
    localparam int PS_W  = 13;
    localparam int HS_W  = 11;
    localparam int STK_DEPTH = 8;

    localparam logic [TD_W-1:0] TRAP_DEPTH_LIMIT     = 3'h6;
    localparam logic [GL_W-1:0] REG_BANK_DEPTH_LIMIT = 3'h3;
    localparam logic [TD_W-1:0] TD_ONE  = 3'h1;
    localparam logic [GL_W-1:0] GL_ONE  = 3'h1;
    localparam logic [CWP_W-1:0] CWP_ONE        = 3'h1;
    localparam logic [CWP_W-1:0] CWP_SPILL_BIAS = 3'h2;

    // ------------------------------------------------------------
    // Processor state and hyper state bit positions
    // ------------------------------------------------------------
    localparam int PS_IE   = 1;
    localparam int PS_PRIV = 2;
    localparam int PS_AM   = 3;
    localparam int PS_PEF  = 4;
    localparam int PS_MM_LO = 6;
    localparam int PS_MM_HI = 7;
    localparam int PS_TLE  = 8;
    localparam int PS_CLE  = 9;
    localparam int PS_TCT  = 12;
    localparam logic [1:0] MM_TSO = 2'h0;

    localparam int HS_TLZ   = 0;
    localparam int HS_HPRIV = 2;
    localparam int HS_RED   = 5;
    localparam int HS_IBE   = 10;

    localparam logic [PS_W-1:0] PS_RESET = 13'h0000;
    localparam logic [HS_W-1:0] HS_RESET = 11'h024;

    // ------------------------------------------------------------
    // Trap codes and vector offsets
    // ------------------------------------------------------------
    localparam logic [TT_W-1:0] TT_SOFT_RESET = 9'h004;
    localparam logic [TT_W-1:0] TT_CLEAN_WIN  = 9'h024;
    localparam logic [TT_W-1:0] TT_SPILL_LO   = 9'h080;
    localparam logic [TT_W-1:0] TT_SPILL_HI   = 9'h0BF;
    localparam logic [TT_W-1:0] TT_FILL_LO    = 9'h0C0;
    localparam logic [TT_W-1:0] TT_FILL_HI    = 9'h0FF;

    localparam logic [7:0] VEC_SIR_PC  = 8'h80;
    localparam logic [7:0] VEC_SIR_NPC = 8'h84;
    localparam logic [7:0] VEC_RED_PC  = 8'hA0;
    localparam logic [7:0] VEC_RED_NPC = 8'hA4;
    localparam logic [31:0] PC_HI_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PSTATE    = 8'h00;
    localparam logic [7:0] OFS_HPSTATE   = 8'h04;
    localparam logic [7:0] OFS_DEPTHS    = 8'h08;
    localparam logic [7:0] OFS_RVEC_LO   = 8'h0C;
    localparam logic [7:0] OFS_RVEC_HI   = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;
    localparam logic [7:0] OFS_STK_SEL   = 8'h18;
    localparam logic [7:0] OFS_STK_TT    = 8'h1C;
    localparam logic [7:0] OFS_STK_PC_LO = 8'h20;
    localparam logic [7:0] OFS_STK_PC_HI = 8'h24;
    localparam int DP_TD  = 0;
    localparam int DP_GL  = 4;
    localparam int DP_CWP = 8;
    localparam logic [31:0] RVEC_LO_RESET = 32'h0000_0000;
    localparam logic [31:0] RVEC_HI_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ENTER = 2'b01,
        ST_HALT  = 2'b10
    } seq_state_t;

endpackage

/* hdl/trap_stack.sv */
// Purpose : Per-level save stack, one record per trap depth
// Assumes : Single write port, asynchronous read port
// Notes   : Entries carry no reset; software must not trust a level never written
`timescale 1ns/1ps
module trap_stack #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic             hclk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge hclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];
endmodule

/* test/trap_pipe_model.sv */
// Purpose : Pipeline side that raises one trap request and waits for its outcome
// Assumes : Fields are held from launch until trap_ready is seen high at an edge
// Notes   : Code and PC fields scramble once released so a stale value never helps the design
`timescale 1ns/1ps
module trap_pipe_model (
    input  wire logic                              hclk,
    input  wire logic                              trap_ready,
    input  wire logic                              trap_done,
    input  wire logic                              error_mode,
    output logic                                   trap_req,
    output logic                                   soft_reset_instr,
    output logic [trap_entry_pkg::TT_W-1:0]        trap_kind_code,
    output logic [63:0]                            cur_pc,
    output logic [63:0]                            cur_next_pc,
    output logic [7:0]                             cur_ccr,
    output logic [7:0]                             cur_asi,
    output logic [trap_entry_pkg::CWP_W-1:0]       free_window_count
);
    import trap_entry_pkg::*;
    initial {trap_req, soft_reset_instr, trap_kind_code, cur_pc, cur_next_pc} = '0;
    initial {cur_ccr, cur_asi, free_window_count} = '0;
    // Result: 1 handler entered, 2 halted, 0 nothing seen
    task automatic launch(input logic s, input logic [8:0] c, input logic [63:0] p,
                          input logic [2:0] f, output int res);
        int n;
        res = 0;
        @(posedge hclk);
        {trap_req, soft_reset_instr, trap_kind_code, free_window_count} <= {1'b1, s, c, f};
        {cur_pc, cur_next_pc, cur_ccr, cur_asi} <= {p, p + 64'h4, p[15:0]};
        for (n = 0; n < 20; n++)
        begin
            @(posedge hclk);
            if (trap_ready === 1'b1)
                break;
        end
        {trap_req, trap_kind_code, cur_pc, cur_next_pc} <= {1'b0, ~c, ~p, p ^ 64'h55};
        for (n = 0; n < 6 && res == 0; n++)
        begin
            @(posedge hclk);
            res = (trap_done === 1'b1) ? 1 : (error_mode === 1'b1) ? 2 : 0;
        end
    endtask
endmodule

/* test/testbench.sv */
// Purpose : Drives soft reset and recovery traps, checks vectors, state and stacks
// Assumes : Zero wait-state bus; trap depth starts at 0 after reset
// Notes   : Expected depth, bank and window values come from integer copies of each
`timescale 1ns/1ps
module testbench;
    import trap_entry_pkg::*;
    logic hclk = 0, hresetn = 0, hsel, hwrite, trap_req, sri, hready, hresp, tdone, emode;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [8:0] tkc, codes [5];
    logic [63:0] cpc, cnpc, next_pc, nnpc, rv, pc;
    logic [7:0] ccr, asi;
    logic [2:0] fwc;
    logic trdy;
    int err_total = 0, comparisons = 0, res, td = 0, gl = 0, cwp = 0, k;
    logic [31:0] seed = 32'hd9f4;
    initial forever #2 hclk = ~hclk;
    wire hreadyout_w;
    assign hready = hreadyout_w;
    reset_mode_trap_entry i_reset_mode_trap_entry (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout_w),
        .hresp(hresp), .trap_req(trap_req), .soft_reset_instr(sri), .trap_kind_code(tkc),
        .cur_pc(cpc), .cur_next_pc(cnpc), .cur_ccr(ccr), .cur_asi(asi),
        .free_window_count(fwc), .trap_ready(trdy), .trap_done(tdone), .new_pc(next_pc),
        .new_next_pc(nnpc), .error_mode(emode));
    trap_pipe_model i_trap_pipe_model (.hclk(hclk), .trap_ready(trdy), .trap_done(tdone),
        .error_mode(emode), .trap_req(trap_req), .soft_reset_instr(sri),
        .trap_kind_code(tkc), .cur_pc(cpc), .cur_next_pc(cnpc), .cur_ccr(ccr),
        .cur_asi(asi), .free_window_count(fwc));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [127:0] g, input logic [127:0] e);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rdy();
        int n;
        for (n = 0; n < 50; n++)
        begin
            @(posedge hclk);
            if (hready === 1'b1)
                return;
        end
        err_total++;
        tally_and_finish();
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
        rdy();
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        rdy();
        r = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(r, e);
    endtask
    // Launch one trap and check its outcome, vectors, depths, state and saved record; window step modulo eight
    task automatic trap(input logic s, input logic [8:0] c, input logic [2:0] f);
        pc = {xs(), xs()};
        i_trap_pipe_model.launch(s, c, pc, f, res);
        // A soft reset records its own fixed code, so the window step follows that code
        if (s)
            c = TT_SOFT_RESET;
        chk(res, (td == 6) ? 2 : 1);
        if (td == 6)
            return;
        td++;
        gl = (gl < 3) ? gl + 1 : 3;
        cwp = (cwp + ((c == 9'h024) ? 1 : (c >= 9'h080 && c <= 9'h0BF) ? f + 2 :
              (c >= 9'h0C0 && c <= 9'h0FF) ? 7 : 0)) % 8;
        chk({next_pc, nnpc}, {rv[63:8], s ? 8'h80 : 8'hA0, rv[63:8], s ? 8'h84 : 8'hA4});
        rd(OFS_DEPTHS, (cwp << 8) | (gl << 4) | td);
        rd(OFS_HPSTATE, 32'h0000_0024);
        rd(OFS_PSTATE, 32'h0000_0110);
        bus(1'b1, OFS_STK_SEL, td);
        rd(OFS_STK_TT, s ? 32'h0000_0004 : {23'h0, c});
        rd(OFS_STK_PC_HI, s ? 32'h0000_0000 : pc[63:32]);
        rd(OFS_STK_PC_LO, pc[31:0]);
        $display("trap code %h depth %0d done", c, td);
    endtask
    initial
    begin
        {hsel, htrans, hwrite, haddr, hwdata} <= '0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(OFS_HPSTATE, {21'h0, HS_RESET});
        chk(hresp, 1'b0);
        rd(8'hFC, 32'h0000_0000);
        rv = {xs(), xs()};
        bus(1'b1, OFS_RVEC_LO, rv[31:0]);
        bus(1'b1, OFS_RVEC_HI, rv[63:32]);
        bus(1'b1, OFS_PSTATE, 32'h0000_13DE);
        bus(1'b1, OFS_HPSTATE, 32'h0000_0020);
        i_trap_pipe_model.launch(1'b1, 9'h004, 64'h0, 3'h0, res);
        chk(res, 0);
        rd(OFS_DEPTHS, 32'h0000_0000);
        $display("soft reset outside hyper mode ignored done");
        bus(1'b1, OFS_HPSTATE, 32'h0000_0425);
        trap(1'b1, 9'(xs()), 3'h5);
        codes = '{9'h024, 9'h080, 9'h0FF, 9'h025, 9'(xs())};
        for (k = 0; k < 5; k++)
            trap(1'b0, codes[k], 3'(xs()));
        trap(1'b0, 9'h030, 3'h1);
        chk(emode, 1'b1);
        rd(OFS_DEPTHS, (cwp << 8) | (gl << 4) | td);
        $display("halt at depth limit done");
        tally_and_finish();
    end
endmodule
